//--- hw/mmd_memory_map.sv
// Memory map, stacks and I/O decode of the small USB microcontroller.
// Assumes the core issues at most one I/O access and one stack op per cycle.
`timescale 1ns/1ps

// How it works
// - 4 KB program store from address zero.
// - Lowest 16 bytes hold eight vectors.
// - Program counter starts at zero after reset.
// - Secured part returns 0xFF to programmer.
// - 128 bytes of data RAM shared.
// - Top 16 bytes are two endpoint FIFOs.
// - Return stack pointer resets to zero.
// - Call adds two, return subtracts two.
// - Push pre-decrements then writes.
// - Pop reads then post-increments.
// - Data stack pointer resets to zero.
// - I/O reached only by I/O instructions.
// - Port data registers at 0x00, 0x01.
// - Write-only pin interrupt enables 0x04, 0x05.
// - Write-only pull-up controls 0x08, 0x09.
// - USB registers at 0x10 through 0x14.
// - Watchdog clear write-only at 0x21.
// - Interrupt enable, RC pin, timer at 0x20-0x23.
// - Per-pin sink current registers 0x30-0x3F.
// - Processor status/control at 0xFF.
// - Reset restores defaults, address zero, interrupts off.
module mmd_memory_map #(
  parameter int unsigned PROG_ADDR_W = 12,
  parameter int unsigned RAM_ADDR_W  = 7
) (
  input  wire logic                     clk,
  input  wire logic                     reset,
  input  wire logic                     pc_advance,
  input  wire logic                     pc_load,
  input  wire logic [PROG_ADDR_W-1:0]   pc_target,
  output logic      [PROG_ADDR_W-1:0]   pc,
  output logic      [7:0]               fetch_data,
  input  wire logic                     prog_wr,
  input  wire logic [PROG_ADDR_W-1:0]   prog_addr,
  input  wire logic [7:0]               prog_wdata,
  input  wire logic                     prog_rd,
  output logic      [7:0]               prog_rdata,
  input  wire logic                     security_fuse,
  input  wire logic [2:0]               vector_index,
  output logic      [PROG_ADDR_W-1:0]   vector_addr,
  input  wire mmd_pkg::mmd_stack_op_type stack_op,
  input  wire logic [7:0]               stack_wdata,
  output logic      [7:0]               stack_rdata,
  output logic      [7:0]               return_stack_pointer,
  output logic      [7:0]               data_stack_pointer,
  input  wire logic                     ram_wr,
  input  wire logic [7:0]               ram_addr,
  input  wire logic [7:0]               ram_wdata,
  output logic      [7:0]               ram_rdata,
  input  wire mmd_pkg::mmd_io_req_type  io_req,
  output logic      [7:0]               io_rdata,
  output logic                          io_hit,
  output logic                          watchdog_clear,
  input  wire logic [7:0]               free_running_timer,
  output mmd_pkg::mmd_io_regs_type      io_regs,
  output logic      [31:0]              port0_sink_current,
  output logic      [31:0]              port1_sink_current
);

  // ***************************************************************
  // Helpers
  // ***************************************************************
  function automatic logic [RAM_ADDR_W-1:0] ram_index(input logic [7:0] a);
    ram_index = a[RAM_ADDR_W-1:0];
  endfunction

  // ***************************************************************
  // Program memory and program counter
  // ***************************************************************
  logic [7:0]             prog_mem [0:mmd_pkg::PROG_BYTES-1];
  logic [PROG_ADDR_W-1:0] pc_q;
  logic [PROG_ADDR_W-1:0] pc_d;

  assign pc_d = pc_load ? pc_target : (pc_advance ? pc_q + 1'b1 : pc_q);
  // Each vector is two bytes, so slot n starts at byte 2n.
  assign vector_addr = {{(PROG_ADDR_W-4){1'b0}}, vector_index, 1'b0};
  assign pc = pc_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pc_q <= mmd_pkg::RESET_PC;
    end else begin
      pc_q <= pc_d;
    end
  end

  always_ff @(posedge clk) begin
    if (prog_wr) begin
      prog_mem[prog_addr] <= prog_wdata;
    end
    fetch_data <= prog_mem[pc_q];
    prog_rdata <= security_fuse ? mmd_pkg::SECURED_BYTE : prog_mem[prog_addr];
  end

  // ***************************************************************
  // Data RAM and stack pointers
  // ***************************************************************
  logic [7:0] ram [0:mmd_pkg::RAM_BYTES-1];
  logic [7:0] rsp_q;
  logic [7:0] rsp_d;
  logic [7:0] dsp_q;
  logic [7:0] dsp_d;
  logic [7:0] push_addr;
  logic       push_en;
  logic       pop_en;

  assign push_en   = (stack_op == mmd_pkg::STK_PUSH);
  assign pop_en    = (stack_op == mmd_pkg::STK_POP);
  assign push_addr = dsp_q - mmd_pkg::DSP_STEP;

  always_comb begin
    rsp_d = rsp_q;
    dsp_d = dsp_q;
    unique case (stack_op)
      mmd_pkg::STK_CALL: rsp_d = rsp_q + mmd_pkg::RSP_STEP;
      mmd_pkg::STK_RET:  rsp_d = rsp_q - mmd_pkg::RSP_STEP;
      mmd_pkg::STK_PUSH: dsp_d = push_addr;
      mmd_pkg::STK_POP:  dsp_d = dsp_q + mmd_pkg::DSP_STEP;
      mmd_pkg::STK_LOAD: dsp_d = stack_wdata;
      mmd_pkg::STK_NONE: dsp_d = dsp_q;
      default:           dsp_d = dsp_q;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rsp_q <= mmd_pkg::RSP_RESET;
      dsp_q <= mmd_pkg::DSP_RESET;
    end else begin
      rsp_q <= rsp_d;
      dsp_q <= dsp_d;
    end
  end

  // The data stack pointer is 8 bits but only its low bits index RAM, so it wraps.
  always_ff @(posedge clk) begin
    if (push_en) begin
      ram[ram_index(push_addr)] <= stack_wdata;
    end else if (ram_wr) begin
      ram[ram_index(ram_addr)] <= ram_wdata;
    end
    stack_rdata <= ram[ram_index(dsp_q)];
    ram_rdata   <= ram[ram_index(ram_addr)];
  end

  assign return_stack_pointer = rsp_q;
  assign data_stack_pointer   = dsp_q;

  // ***************************************************************
  // I/O decode
  // ***************************************************************
  mmd_pkg::mmd_io_regs_type regs_q;
  logic [3:0]               sink0_q [0:7];
  logic [3:0]               sink1_q [0:7];
  logic                     wr_en;
  logic                     rd_en;
  logic                     sink0_hit;
  logic                     sink1_hit;
  logic                     rw_hit;
  logic                     wo_hit;
  logic [7:0]               rd_mux;

  // Only the I/O instructions drive io_req; no memory path reaches here.
  assign wr_en     = io_req.wr;
  assign rd_en     = io_req.rd;
  assign sink0_hit = (io_req.addr[7:3] == mmd_pkg::IO_PORT0_SINK[7:3]);
  assign sink1_hit = (io_req.addr[7:3] == mmd_pkg::IO_PORT1_SINK[7:3]);

  always_comb begin
    rw_hit = 1'b1;
    rd_mux = 8'h00;
    unique case (io_req.addr)
      mmd_pkg::IO_PORT0_DATA:  rd_mux = regs_q.port0_data;
      mmd_pkg::IO_PORT1_DATA:  rd_mux = regs_q.port1_data;
      mmd_pkg::IO_EP0_TX_CFG:  rd_mux = regs_q.endpoint0_tx_config;
      mmd_pkg::IO_EP1_TX_CFG:  rd_mux = regs_q.endpoint1_tx_config;
      mmd_pkg::IO_USB_ADDR:    rd_mux = regs_q.usb_device_address;
      mmd_pkg::IO_USB_SC:      rd_mux = regs_q.usb_status_control;
      mmd_pkg::IO_EP0_RX_STAT: rd_mux = regs_q.endpoint0_rx_status;
      mmd_pkg::IO_GLOBAL_IE:   rd_mux = regs_q.global_irq_enable;
      mmd_pkg::IO_RC_PIN:      rd_mux = regs_q.rc_timing_pin_ctrl;
      mmd_pkg::IO_TIMER:       rd_mux = free_running_timer;
      mmd_pkg::IO_PROC_SC:     rd_mux = regs_q.processor_status_control;
      default: begin
        rw_hit = 1'b0;
        rd_mux = 8'h00;
      end
    endcase
  end

  assign wo_hit = sink0_hit || sink1_hit
                  || (io_req.addr == mmd_pkg::IO_PORT0_IE)
                  || (io_req.addr == mmd_pkg::IO_PORT1_IE)
                  || (io_req.addr == mmd_pkg::IO_PORT0_PULLUP)
                  || (io_req.addr == mmd_pkg::IO_PORT1_PULLUP)
                  || (io_req.addr == mmd_pkg::IO_WDOG_CLEAR);
  assign io_hit = rw_hit || wo_hit;

  // Any write to the watchdog location restarts it; nothing is stored.
  assign watchdog_clear = wr_en && (io_req.addr == mmd_pkg::IO_WDOG_CLEAR);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      io_rdata <= 8'h00;
    end else if (rd_en) begin
      io_rdata <= rd_mux;
    end
  end

  // ***************************************************************
  // Write strobes, one per stored register
  // ***************************************************************
  // Named strobes keep the write process a flat list of loads.
  function automatic logic write_to(input logic we, input logic [7:0] a,
                                    input logic [7:0] loc);
    write_to = we && (a == loc);
  endfunction

  // Port registers.
  logic we_port0_data;
  logic we_port1_data;
  logic we_port0_ie;
  logic we_port1_ie;
  logic we_port0_pullup;
  logic we_port1_pullup;

  // USB registers.
  logic we_ep0_tx_cfg;
  logic we_ep1_tx_cfg;
  logic we_usb_addr;
  logic we_usb_sc;
  logic we_ep0_rx_stat;

  // System registers.
  logic we_global_ie;
  logic we_rc_pin;
  logic we_proc_sc;

  // The indexed write form reaches here with its address already resolved.
  assign we_port0_data   = write_to(wr_en, io_req.addr, mmd_pkg::IO_PORT0_DATA);
  assign we_port1_data   = write_to(wr_en, io_req.addr, mmd_pkg::IO_PORT1_DATA);
  assign we_port0_ie     = write_to(wr_en, io_req.addr, mmd_pkg::IO_PORT0_IE);
  assign we_port1_ie     = write_to(wr_en, io_req.addr, mmd_pkg::IO_PORT1_IE);
  assign we_port0_pullup = write_to(wr_en, io_req.addr, mmd_pkg::IO_PORT0_PULLUP);
  assign we_port1_pullup = write_to(wr_en, io_req.addr, mmd_pkg::IO_PORT1_PULLUP);

  assign we_ep0_tx_cfg   = write_to(wr_en, io_req.addr, mmd_pkg::IO_EP0_TX_CFG);
  assign we_ep1_tx_cfg   = write_to(wr_en, io_req.addr, mmd_pkg::IO_EP1_TX_CFG);
  assign we_usb_addr     = write_to(wr_en, io_req.addr, mmd_pkg::IO_USB_ADDR);
  assign we_usb_sc       = write_to(wr_en, io_req.addr, mmd_pkg::IO_USB_SC);
  assign we_ep0_rx_stat  = write_to(wr_en, io_req.addr, mmd_pkg::IO_EP0_RX_STAT);

  assign we_global_ie    = write_to(wr_en, io_req.addr, mmd_pkg::IO_GLOBAL_IE);
  assign we_rc_pin       = write_to(wr_en, io_req.addr, mmd_pkg::IO_RC_PIN);
  assign we_proc_sc      = write_to(wr_en, io_req.addr, mmd_pkg::IO_PROC_SC);

  // Reset brings every register to its default and all enables off.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      regs_q.port0_data               <= mmd_pkg::PORT_DATA_RESET;
      regs_q.port1_data               <= mmd_pkg::PORT_DATA_RESET;
      regs_q.port0_pin_irq_enable     <= mmd_pkg::ZERO_RESET;
      regs_q.port1_pin_irq_enable     <= mmd_pkg::ZERO_RESET;
      regs_q.port0_pullup_ctrl        <= mmd_pkg::PULLUP_RESET;
      regs_q.port1_pullup_ctrl        <= mmd_pkg::PULLUP_RESET;
      regs_q.endpoint0_tx_config      <= mmd_pkg::ZERO_RESET;
      regs_q.endpoint1_tx_config      <= mmd_pkg::ZERO_RESET;
      regs_q.usb_device_address       <= mmd_pkg::ZERO_RESET;
      regs_q.usb_status_control       <= mmd_pkg::ZERO_RESET;
      regs_q.endpoint0_rx_status      <= mmd_pkg::ZERO_RESET;
      regs_q.global_irq_enable        <= mmd_pkg::ZERO_RESET;
      regs_q.rc_timing_pin_ctrl       <= mmd_pkg::RC_PIN_RESET;
      regs_q.processor_status_control <= mmd_pkg::PROC_SC_RESET;
    end else begin
      if (we_port0_data) begin
        regs_q.port0_data <= io_req.wdata;
      end

      if (we_port1_data) begin
        regs_q.port1_data <= io_req.wdata;
      end

      // Write-only stores still hold their value; reading them gives zero.
      if (we_port0_ie) begin
        regs_q.port0_pin_irq_enable <= io_req.wdata;
      end

      if (we_port1_ie) begin
        regs_q.port1_pin_irq_enable <= io_req.wdata;
      end

      if (we_port0_pullup) begin
        regs_q.port0_pullup_ctrl <= io_req.wdata;
      end

      if (we_port1_pullup) begin
        regs_q.port1_pullup_ctrl <= io_req.wdata;
      end

      // USB registers are plain stores here; the engine reads them as given.
      if (we_ep0_tx_cfg) begin
        regs_q.endpoint0_tx_config <= io_req.wdata;
      end

      if (we_ep1_tx_cfg) begin
        regs_q.endpoint1_tx_config <= io_req.wdata;
      end

      if (we_usb_addr) begin
        regs_q.usb_device_address <= io_req.wdata;
      end

      if (we_usb_sc) begin
        regs_q.usb_status_control <= io_req.wdata;
      end

      if (we_ep0_rx_stat) begin
        regs_q.endpoint0_rx_status <= io_req.wdata;
      end

      // System control registers.
      if (we_global_ie) begin
        regs_q.global_irq_enable <= io_req.wdata;
      end

      if (we_rc_pin) begin
        regs_q.rc_timing_pin_ctrl <= io_req.wdata;
      end

      // Reserved bits are forced to zero so software cannot set them.
      if (we_proc_sc) begin
        regs_q.processor_status_control <= io_req.wdata & mmd_pkg::PROC_SC_WMASK;
      end
    end
  end

  // ***************************************************************
  // Sink current registers, one nibble per pin
  // ***************************************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < 8; i++) begin
        sink0_q[i] <= mmd_pkg::SINK_RESET;
        sink1_q[i] <= mmd_pkg::SINK_RESET;
      end
    end else if (wr_en && sink0_hit) begin
      sink0_q[io_req.addr[2:0]] <= io_req.wdata[3:0];
    end else if (wr_en && sink1_hit) begin
      sink1_q[io_req.addr[2:0]] <= io_req.wdata[3:0];
    end
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      port0_sink_current[i*4 +: 4] = sink0_q[i];
      port1_sink_current[i*4 +: 4] = sink1_q[i];
    end
  end

  assign io_regs = regs_q;

endmodule

//--- common/mmd_pkg.sv
// Package for the memory map, stack pointer and I/O decode block.
// Assumes one core clock and one device reset shared by every user.
package mmd_pkg;

  // ***************************************************************
  // Memory sizes
  // ***************************************************************
  localparam int unsigned PROG_BYTES      = 4096;
  localparam int unsigned VECTOR_BYTES    = 16;
  localparam int unsigned VECTOR_SIZE     = 2;
  localparam int unsigned RAM_BYTES       = 128;
  localparam logic [7:0]  EP0_FIFO_BASE   = 8'h70;
  localparam logic [7:0]  EP1_FIFO_BASE   = 8'h78;
  localparam logic [11:0] RESET_PC        = 12'h000;
  localparam logic [7:0]  SECURED_BYTE    = 8'hFF;
  localparam logic [7:0]  RSP_RESET       = 8'h00;
  localparam logic [7:0]  DSP_RESET       = 8'h00;
  localparam logic [7:0]  RSP_STEP        = 8'h02;
  localparam logic [7:0]  DSP_STEP        = 8'h01;

  // ***************************************************************
  // I/O addresses
  // ***************************************************************
  localparam logic [7:0] IO_PORT0_DATA   = 8'h00;
  localparam logic [7:0] IO_PORT1_DATA   = 8'h01;
  localparam logic [7:0] IO_PORT0_IE     = 8'h04;
  localparam logic [7:0] IO_PORT1_IE     = 8'h05;
  localparam logic [7:0] IO_PORT0_PULLUP = 8'h08;
  localparam logic [7:0] IO_PORT1_PULLUP = 8'h09;
  localparam logic [7:0] IO_EP0_TX_CFG   = 8'h10;
  localparam logic [7:0] IO_EP1_TX_CFG   = 8'h11;
  localparam logic [7:0] IO_USB_ADDR     = 8'h12;
  localparam logic [7:0] IO_USB_SC       = 8'h13;
  localparam logic [7:0] IO_EP0_RX_STAT  = 8'h14;
  localparam logic [7:0] IO_GLOBAL_IE    = 8'h20;
  localparam logic [7:0] IO_WDOG_CLEAR   = 8'h21;
  localparam logic [7:0] IO_RC_PIN       = 8'h22;
  localparam logic [7:0] IO_TIMER        = 8'h23;
  localparam logic [7:0] IO_PORT0_SINK   = 8'h30;
  localparam logic [7:0] IO_PORT1_SINK   = 8'h38;
  localparam logic [7:0] IO_PROC_SC      = 8'hFF;

  // ***************************************************************
  // Reset values
  // ***************************************************************
  localparam logic [7:0] PORT_DATA_RESET = 8'hFF;
  localparam logic [7:0] ZERO_RESET      = 8'h00;
  localparam logic [7:0] PULLUP_RESET    = 8'h00;
  localparam logic [7:0] RC_PIN_RESET    = 8'h00;
  localparam logic [7:0] PROC_SC_RESET   = 8'h19;
  localparam logic [7:0] PROC_SC_WMASK   = 8'h79;
  localparam logic [3:0] SINK_RESET      = 4'h0;

  // Stack operation requested by the core in one cycle.
  typedef enum logic [2:0] {
    STK_NONE = 3'b000,
    STK_CALL = 3'b001,
    STK_RET  = 3'b010,
    STK_PUSH = 3'b011,
    STK_POP  = 3'b100,
    STK_LOAD = 3'b101
  } mmd_stack_op_type;

  // One I/O access from the core.
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       indexed;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mmd_io_req_type;

  // Outputs from I/O registers to the peripherals.
  typedef struct packed {
    logic [7:0] port0_data;
    logic [7:0] port1_data;
    logic [7:0] port0_pin_irq_enable;
    logic [7:0] port1_pin_irq_enable;
    logic [7:0] port0_pullup_ctrl;
    logic [7:0] port1_pullup_ctrl;
    logic [7:0] endpoint0_tx_config;
    logic [7:0] endpoint1_tx_config;
    logic [7:0] usb_device_address;
    logic [7:0] usb_status_control;
    logic [7:0] endpoint0_rx_status;
    logic [7:0] global_irq_enable;
    logic [7:0] rc_timing_pin_ctrl;
    logic [7:0] processor_status_control;
  } mmd_io_regs_type;

endpackage

//--- bench/mmd_memory_map_assertions.sv
// Concurrent checks on the ports of the memory map block.
// Assumes one clock and the block's asynchronous active-high reset.
`timescale 1ns/1ps
module mmd_memory_map_assertions #(
  parameter int unsigned PROG_ADDR_W = 12
) (
  input wire logic                      clk,
  input wire logic                      reset,
  input wire logic [PROG_ADDR_W-1:0]    pc,
  input wire logic                      security_fuse,
  input wire logic [7:0]                prog_rdata,
  input wire logic [2:0]                vector_index,
  input wire logic [PROG_ADDR_W-1:0]    vector_addr,
  input wire mmd_pkg::mmd_stack_op_type stack_op,
  input wire logic [7:0]                return_stack_pointer,
  input wire logic [7:0]                data_stack_pointer,
  input wire mmd_pkg::mmd_io_req_type   io_req,
  input wire logic [7:0]                io_rdata,
  input wire logic                      io_hit,
  input wire logic                      watchdog_clear
);
  // ****************************************
  // Checks
  // ****************************************
  wire [7:0] rsp = return_stack_pointer;
  wire [7:0] dsp = data_stack_pointer;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  reset_state_a: assert property ($fell(reset) |-> pc == '0 && rsp == 8'h00 && dsp == 8'h00)
    else $error("pointers not cleared by reset");
  secured_read_a: assert property (security_fuse |=> prog_rdata == 8'hFF)
    else $error("secured read not blanked");
  vector_slot_a: assert property (vector_addr == PROG_ADDR_W'({vector_index, 1'b0}))
    else $error("vector address wrong");
  call_step_a: assert property (stack_op == mmd_pkg::STK_CALL |=> rsp == $past(rsp) + 8'h02)
    else $error("call step wrong");
  ret_step_a: assert property (stack_op == mmd_pkg::STK_RET |=> rsp == $past(rsp) - 8'h02)
    else $error("return step wrong");
  push_step_a: assert property (stack_op == mmd_pkg::STK_PUSH |=> 7'(dsp - $past(dsp)) == 7'h7F)
    else $error("push step wrong");
  pop_step_a: assert property (stack_op == mmd_pkg::STK_POP |=> 7'(dsp - $past(dsp)) == 7'h01)
    else $error("pop step wrong");
  unmapped_read_a: assert property (io_req.rd && !io_hit |=> io_rdata == 8'h00)
    else $error("unmapped read not zero");
  watchdog_pulse_a: assert property (watchdog_clear == (io_req.wr && io_req.addr == 8'h21))
    else $error("watchdog clear pulse wrong");
  read_hold_a: assert property (!io_req.rd |=> $stable(io_rdata))
    else $error("read data moved without a read");
  cover property (stack_op == mmd_pkg::STK_PUSH ##1 stack_op == mmd_pkg::STK_POP);
  cover property (io_req.wr && io_req.addr == 8'hFF);
  cover property (security_fuse && $rose(security_fuse));
endmodule

bind mmd_memory_map mmd_memory_map_assertions #(.PROG_ADDR_W(PROG_ADDR_W)) u_chk (
  .clk, .reset, .pc, .security_fuse, .prog_rdata, .vector_index, .vector_addr, .stack_op,
  .return_stack_pointer, .data_stack_pointer, .io_req, .io_rdata, .io_hit, .watchdog_clear);

//--- bench/mmd_core_model.sv
// Model of the processor core issuing I/O and stack operations.
// Assumes the caller's sequence; every change lands at a falling edge.
`timescale 1ns/1ps
module mmd_core_model (
  input wire logic                  clk,
  output mmd_pkg::mmd_io_req_type   io_req,
  output mmd_pkg::mmd_stack_op_type stack_op,
  output logic [7:0]                stack_wdata
);
  // ****************************************
  // Operations, one cycle each
  // ****************************************
  initial begin
    io_req = '0;
    stack_op = mmd_pkg::STK_NONE;
    stack_wdata = 8'h00;
  end
  // Registers are only reached by these I/O requests.
  task automatic io_op(input logic r, input logic w, input logic x, input logic [7:0] a,
                       input logic [7:0] d);
    @(negedge clk);
    io_req = '{rd: r, wr: w, indexed: x, addr: a, wdata: d};
    stack_op = mmd_pkg::STK_NONE;
  endtask
  task automatic stk(input mmd_pkg::mmd_stack_op_type op, input logic [7:0] d);
    @(negedge clk);
    io_req = '0;
    stack_op = op;
    stack_wdata = d;
  endtask
  // Released lines show inverted data so stale values cannot pass.
  task automatic idle();
    @(negedge clk);
    io_req = '{rd: 1'b0, wr: 1'b0, indexed: 1'b0, addr: ~io_req.addr, wdata: ~io_req.wdata};
    stack_op = mmd_pkg::STK_NONE;
    stack_wdata = ~stack_wdata;
  endtask
endmodule

//--- bench/mmd_memory_map_tb.sv
// Self-checking bench for the memory map block.
// Assumes the core model drives I/O and stack requests.
`timescale 1ns/1ps
module mmd_memory_map_tb;
  // ****************************************
  // Bench
  // ****************************************
  logic clk = 1'b0, reset = 1'b1, pc_advance = 1'b0, pc_load = 1'b0, prog_wr = 1'b0;
  logic prog_rd = 1'b0, security_fuse = 1'b0, io_hit, wdog;
  logic [11:0] pc_target = 12'h000, prog_addr = 12'h000, pc, vector_addr;
  logic [7:0] prog_wdata = 8'h00, ram_addr = 8'h7F, tmr = 8'h00, a, d, m_rsp, m_dsp;
  logic [7:0] fetch_data, prog_rdata, stack_rdata, rsp, dsp, ram_rdata, io_rdata, stack_wdata;
  logic [7:0] mem [128];
  bit vld [128];
  logic [2:0] vector_index = 3'h0;
  logic [31:0] sink0, sink1, r;
  mmd_pkg::mmd_stack_op_type stack_op, op;
  mmd_pkg::mmd_io_req_type io_req;
  mmd_pkg::mmd_io_regs_type regs;
  int n_errors = 0, compares = 0, seed = 41, cycles = 0;
  always #2 clk = ~clk;
  mmd_memory_map dut (.clk, .reset, .pc_advance, .pc_load, .pc_target, .pc, .fetch_data,
    .prog_wr, .prog_addr, .prog_wdata, .prog_rd, .prog_rdata, .security_fuse, .vector_index,
    .vector_addr, .stack_op, .stack_wdata, .stack_rdata, .return_stack_pointer(rsp),
    .data_stack_pointer(dsp), .ram_wr(1'b0), .ram_addr, .ram_wdata(8'h00), .ram_rdata,
    .io_req, .io_rdata, .io_hit, .watchdog_clear(wdog), .free_running_timer(tmr),
    .io_regs(regs), .port0_sink_current(sink0), .port1_sink_current(sink1));
  mmd_core_model core (.clk, .io_req, .stack_op, .stack_wdata);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic test_done();
    if (n_errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      test_done();
    end
  end
  function automatic logic [7:0] exp_rd(input logic [7:0] ad, input logic [7:0] wd);
    case (ad)
      8'h00, 8'h01, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h20, 8'h22: return wd;
      8'hFF: return wd & 8'h79;
      8'h23: return tmr;
      default: return 8'h00;
    endcase
  endfunction
  function automatic logic [7:0] wo_val(input logic [7:0] ad);
    case (ad)
      8'h04: return regs.port0_pin_irq_enable;
      8'h05: return regs.port1_pin_irq_enable;
      8'h08: return regs.port0_pullup_ctrl;
      8'h09: return regs.port1_pullup_ctrl;
      default: return {4'h0, ad[3] ? sink1[ad[2:0]*4 +: 4] : sink0[ad[2:0]*4 +: 4]};
    endcase
  endfunction
  task automatic do_reset();
    mmd_pkg::mmd_io_regs_type e;
    reset = 1'b1;
    repeat (10) @(negedge clk);
    reset = 1'b0;
    e = '0;
    e.port0_data = 8'hFF;
    e.port1_data = 8'hFF;
    e.processor_status_control = 8'h19;
    check(regs === e, 1'b1, "register defaults");
    check({pc, rsp, dsp}, 28'h000_0000, "pointers after reset");
  endtask
  initial begin
    do_reset();
    for (int i = 0; i < 256; i++) begin
      a = 8'(i);
      d = 8'($random(seed));
      tmr = 8'($random(seed));
      vector_index = a[2:0];
      core.io_op(1'b0, 1'b1, a[0], a, d);
      #1 check(io_hit, a inside {8'h00, 8'h01, 8'h04, 8'h05, 8'h08, 8'h09, [8'h10:8'h14],
        [8'h20:8'h23], [8'h30:8'h3F], 8'hFF}, "decode");
      check(wdog, a == 8'h21, "watchdog clear");
      core.io_op(1'b1, 1'b0, 1'b0, a, 8'h00);
      core.idle();
      check(io_rdata, exp_rd(a, d), "read back");
      if (a inside {8'h04, 8'h05, 8'h08, 8'h09, [8'h30:8'h3F]})
        check(wo_val(a), a[5] ? {4'h0, d[3:0]} : d, "write-only");
    end
    prog_addr = 12'hFFE;
    prog_wdata = d;
    prog_wr = 1'b1;
    pc_target = 12'hFFE;
    pc_load = 1'b1;
    @(negedge clk);
    prog_wr = 1'b0;
    pc_load = 1'b0;
    pc_advance = 1'b1;
    prog_rd = 1'b1;
    @(negedge clk);
    pc_advance = 1'b0;
    check({pc, fetch_data, prog_rdata}, {12'hFFF, d, d}, "program store");
    security_fuse = 1'b1;
    @(negedge clk);
    check(prog_rdata, 8'hFF, "secured read");
    security_fuse = 1'b0;
    core.stk(mmd_pkg::STK_LOAD, 8'h70);
    m_dsp = 8'h70;
    m_rsp = 8'h00;
    for (int i = 0; i < 80; i++) begin
      r = $random(seed);
      op = mmd_pkg::mmd_stack_op_type'({1'b0, r[1:0]} + 3'h1);
      core.stk(op, r[15:8]);
      case (op)
        mmd_pkg::STK_CALL: m_rsp += 8'h02;
        mmd_pkg::STK_RET: m_rsp -= 8'h02;
        mmd_pkg::STK_PUSH: begin
          m_dsp--;
          mem[m_dsp[6:0]] = r[15:8];
          vld[m_dsp[6:0]] = 1'b1;
        end
        default: m_dsp++;
      endcase
      core.idle();
      core.idle();
      check({rsp, 1'b0, dsp[6:0]}, {m_rsp, 1'b0, m_dsp[6:0]}, "stack pointers");
      if (vld[m_dsp[6:0]]) check(stack_rdata, mem[m_dsp[6:0]], "stack data");
    end
    do_reset();
    core.stk(mmd_pkg::STK_PUSH, 8'h3C);
    core.idle();
    core.idle();
    check({dsp[6:0], stack_rdata, ram_rdata}, {7'h7F, 8'h3C, 8'h3C}, "first push");
    test_done();
  end
endmodule
